// File: src/ppm_consts.svh
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// register addresses on the special-function-register bus
`define PPM_ADDR_P1_MODE_LO 8'hae
`define PPM_ADDR_P1_MODE_HI 8'haf
`define PPM_ADDR_P3_LATCH 8'hb0
`define PPM_ADDR_P2_MODE_LO 8'hb1
`define PPM_ADDR_P2_MODE_HI 8'hb2
`define PPM_ADDR_P3_MODE_LO 8'hb3

// reset values
`define PPM_RST_MODE 8'h00
`define PPM_RST_P3_LATCH 8'hff
`define PPM_RST_RDATA 8'h00

// pin mode encodings
`define PPM_MODE_QUASI 2'b00
`define PPM_MODE_PUSH_PULL 2'b01
`define PPM_MODE_OPEN_DRAIN 2'b10
`define PPM_MODE_INPUT 2'b11

// positions in the flat sampled-input vector
`define PPM_IDX_P1 0
`define PPM_IDX_P2 8
`define PPM_IDX_P3 16
`define PPM_IDX_EA 24
`define PPM_NSAMP 25

// port 3 alternate-function bit positions
`define PPM_P3_RXD 0
`define PPM_P3_TXD 1
`define PPM_P3_IRQ0 2
`define PPM_P3_IRQ1 3
`define PPM_P3_CNT0 4
`define PPM_P3_CNT1 5
`define PPM_P3_WR 6
`define PPM_P3_RD 7

`endif

// File: src/ppm_pkg.sv
package ppm_pkg;

	typedef logic [1:0] ppm_mode_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
	} ppm_drv_s;

	typedef struct packed {
		logic [7:0] p1_lo;
		logic [7:0] p1_hi;
		logic [7:0] p3_latch;
		logic [7:0] p2_lo;
		logic [7:0] p2_hi;
		logic [7:0] p3_lo;
	} ppm_regs_s;

	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic ser0_mode0;
		logic ser0_txd;
		logic ser0_shclk;
		logic ser0_dout;
	} ppm_alt_s;

	typedef struct packed {
		logic cnt0_ext;
		logic cnt1_ext;
		logic irq0_en;
		logic irq1_en;
		logic irq0_edge;
		logic irq1_edge;
	} ppm_evt_cfg_s;

	typedef struct packed {
		logic cnt0;
		logic cnt1;
		logic irq0;
		logic irq1;
		logic ser0_rx;
	} ppm_evt_s;

	typedef struct packed {
		ppm_regs_s regs;
		logic [24:0] sync1;
		logic [24:0] sync2;
		logic [24:0] prev;
		ppm_drv_s p1;
		ppm_drv_s p2;
		ppm_drv_s p3;
		logic [7:0] rdata;
		ppm_evt_s evt;
	} ppm_state_s;

endpackage

// File: src/ppm_pin_cell.sv
`timescale 1ns/1ps
module ppm_pin_cell
	import ppm_pkg::*;
(
	input wire ppm_mode_t mode_i,
	input wire logic data_i,
	input wire logic force_pp_i,
	output logic out_o,
	output logic oe_o,
	output logic pu_o
);
	`include "ppm_consts.svh"

	always_comb
	begin
		out_o = data_i;
		oe_o = 1'b0;
		pu_o = 1'b0;
		if (force_pp_i)
		begin
			oe_o = 1'b1;
		end
		else
		begin
			case (mode_i)
				`PPM_MODE_QUASI:
				begin
					// strong low, weak pull-up for a one
					oe_o = ~data_i;
					pu_o = 1'b1;
				end
				`PPM_MODE_PUSH_PULL:
				begin
					oe_o = 1'b1;
				end
				`PPM_MODE_OPEN_DRAIN:
				begin
					out_o = 1'b0;
					oe_o = ~data_i;
				end
				default:
				begin
					oe_o = 1'b0;
				end
			endcase
		end
	end
endmodule

// File: src/ppm_port.sv
`timescale 1ns/1ps
module ppm_port
	import ppm_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic [7:0] SFR_WDATA_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	output logic [7:0] SFR_RDATA_O,
	input wire logic [7:0] P1_DATA_I,
	input wire logic [7:0] P2_DATA_I,
	input wire logic [7:0] P2_ADDR_I,
	input wire logic EXTERNAL_ACCESS_PIN_N_I,
	input wire logic HW_CONFIG_REG1_MEMSEL_I,
	input wire ppm_alt_s ALT_I,
	input wire ppm_evt_cfg_s EVT_CFG_I,
	input wire logic [7:0] P1_PIN_I,
	input wire logic [7:0] P2_PIN_I,
	input wire logic [7:0] P3_PIN_I,
	output ppm_drv_s P1_DRV_O,
	output ppm_drv_s P2_DRV_O,
	output ppm_drv_s P3_DRV_O,
	output ppm_evt_s EVT_O
);
	`include "ppm_consts.svh"

	ppm_state_s st_reg;
	ppm_state_s st_next;
	ppm_regs_s regs_next;
	logic ext_mem;
	logic [47:0] mode_vec;
	logic [23:0] data_vec;
	logic [23:0] force_vec;
	logic [23:0] cell_out;
	logic [23:0] cell_oe;
	logic [23:0] cell_pu;
	logic [24:0] fall;

	// register writes; pins follow from the new value at the same edge
	always_comb
	begin
		regs_next = st_reg.regs;
		if (SFR_WR_I)
		begin
			case (SFR_ADDR_I)
				`PPM_ADDR_P1_MODE_LO: regs_next.p1_lo = SFR_WDATA_I;
				`PPM_ADDR_P1_MODE_HI: regs_next.p1_hi = SFR_WDATA_I;
				`PPM_ADDR_P3_LATCH: regs_next.p3_latch = SFR_WDATA_I;
				`PPM_ADDR_P2_MODE_LO: regs_next.p2_lo = SFR_WDATA_I;
				`PPM_ADDR_P2_MODE_HI: regs_next.p2_hi = SFR_WDATA_I;
				`PPM_ADDR_P3_MODE_LO: regs_next.p3_lo = SFR_WDATA_I;
				default: regs_next = st_reg.regs;
			endcase
		end
	end

	// external memory: ea pin low or memory-select bit set
	assign ext_mem = ~st_reg.sync2[`PPM_IDX_EA] | HW_CONFIG_REG1_MEMSEL_I;

	// high half of port 3 has no mode register here: quasi
	assign mode_vec = {8'h00, regs_next.p3_lo,
		regs_next.p2_hi, regs_next.p2_lo,
		regs_next.p1_hi, regs_next.p1_lo};

	// port 3 pin data with alternate functions gated by the latch, except the rd and wr strobes in external-memory mode
	always_comb
	begin
		logic [7:0] l;
		logic [7:0] d3;
		l = regs_next.p3_latch;
		d3 = l;
		if (ext_mem)
		begin
			d3[`PPM_P3_RD] = ALT_I.rd_n;
			d3[`PPM_P3_WR] = ALT_I.wr_n;
		end
		else
		begin
			d3[`PPM_P3_RD] = l[`PPM_P3_RD] & ALT_I.rd_n;
			d3[`PPM_P3_WR] = l[`PPM_P3_WR] & ALT_I.wr_n;
		end
		if (ALT_I.ser0_mode0)
		begin
			d3[`PPM_P3_TXD] = l[`PPM_P3_TXD] & ALT_I.ser0_shclk;
			d3[`PPM_P3_RXD] = l[`PPM_P3_RXD] & ALT_I.ser0_dout;
		end
		else
		begin
			d3[`PPM_P3_TXD] = l[`PPM_P3_TXD] & ALT_I.ser0_txd;
			d3[`PPM_P3_RXD] = l[`PPM_P3_RXD];
		end
		data_vec = {d3, ext_mem ? P2_ADDR_I : P2_DATA_I, P1_DATA_I};
		force_vec = 24'h000000;
		if (ext_mem)
		begin
			force_vec[15:8] = 8'hff;
			force_vec[`PPM_IDX_P3 + `PPM_P3_RD] = 1'b1;
			force_vec[`PPM_IDX_P3 + `PPM_P3_WR] = 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 24; gi = gi + 1)
		begin : g_cell
			ppm_pin_cell u_cell (
				.mode_i(mode_vec[2 * gi +: 2]),
				.data_i(data_vec[gi]),
				.force_pp_i(force_vec[gi]),
				.out_o(cell_out[gi]),
				.oe_o(cell_oe[gi]),
				.pu_o(cell_pu[gi])
			);
		end
	endgenerate

	// falling edges seen on the second synchroniser stage only
	assign fall = st_reg.prev & ~st_reg.sync2;

	always_comb
	begin
		st_next = st_reg;
		st_next.regs = regs_next;
		st_next.sync1 = {EXTERNAL_ACCESS_PIN_N_I, P3_PIN_I, P2_PIN_I, P1_PIN_I};
		st_next.sync2 = st_reg.sync1;
		st_next.prev = st_reg.sync2;
		st_next.p1 = '{out: cell_out[7:0], oe: cell_oe[7:0],
			pu: cell_pu[7:0]};
		st_next.p2 = '{out: cell_out[15:8], oe: cell_oe[15:8],
			pu: cell_pu[15:8]};
		st_next.p3 = '{out: cell_out[23:16], oe: cell_oe[23:16],
			pu: cell_pu[23:16]};
		st_next.rdata = `PPM_RST_RDATA;
		if (SFR_RD_I)
		begin
			case (SFR_ADDR_I)
				`PPM_ADDR_P1_MODE_LO: st_next.rdata = st_reg.regs.p1_lo;
				`PPM_ADDR_P1_MODE_HI: st_next.rdata = st_reg.regs.p1_hi;
				`PPM_ADDR_P3_LATCH: st_next.rdata = st_reg.regs.p3_latch;
				`PPM_ADDR_P2_MODE_LO: st_next.rdata = st_reg.regs.p2_lo;
				`PPM_ADDR_P2_MODE_HI: st_next.rdata = st_reg.regs.p2_hi;
				`PPM_ADDR_P3_MODE_LO: st_next.rdata = st_reg.regs.p3_lo;
				default: st_next.rdata = `PPM_RST_RDATA;
			endcase
		end
		st_next.evt.cnt1 = EVT_CFG_I.cnt1_ext &
			fall[`PPM_IDX_P3 + `PPM_P3_CNT1];
		st_next.evt.cnt0 = EVT_CFG_I.cnt0_ext &
			fall[`PPM_IDX_P3 + `PPM_P3_CNT0];
		st_next.evt.irq1 = EVT_CFG_I.irq1_en & (EVT_CFG_I.irq1_edge ?
			fall[`PPM_IDX_P3 + `PPM_P3_IRQ1] :
			~st_reg.sync2[`PPM_IDX_P3 + `PPM_P3_IRQ1]);
		st_next.evt.irq0 = EVT_CFG_I.irq0_en & (EVT_CFG_I.irq0_edge ?
			fall[`PPM_IDX_P3 + `PPM_P3_IRQ0] :
			~st_reg.sync2[`PPM_IDX_P3 + `PPM_P3_IRQ0]);
		st_next.evt.ser0_rx = st_reg.sync2[`PPM_IDX_P3 + `PPM_P3_RXD];
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			st_reg.regs.p1_lo <= `PPM_RST_MODE;
			st_reg.regs.p1_hi <= `PPM_RST_MODE;
			st_reg.regs.p3_latch <= `PPM_RST_P3_LATCH;
			st_reg.regs.p2_lo <= `PPM_RST_MODE;
			st_reg.regs.p2_hi <= `PPM_RST_MODE;
			st_reg.regs.p3_lo <= `PPM_RST_MODE;
			st_reg.sync1 <= 25'h1ffffff;
			st_reg.sync2 <= 25'h1ffffff;
			st_reg.prev <= 25'h1ffffff;
			st_reg.p1 <= '{out: 8'hff, oe: 8'h00, pu: 8'hff};
			st_reg.p2 <= '{out: 8'hff, oe: 8'h00, pu: 8'hff};
			st_reg.p3 <= '{out: 8'hff, oe: 8'h00, pu: 8'hff};
			st_reg.rdata <= `PPM_RST_RDATA;
			st_reg.evt <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign SFR_RDATA_O = st_reg.rdata;
	assign P1_DRV_O = st_reg.p1;
	assign P2_DRV_O = st_reg.p2;
	assign P3_DRV_O = st_reg.p3;
	assign EVT_O = st_reg.evt;
endmodule

// File: dv/ppm_port_monitor.sv
`timescale 1ns/1ps
module ppm_port_monitor
	import ppm_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic [7:0] SFR_WDATA_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	input wire logic [7:0] SFR_RDATA_O,
	input wire logic [7:0] P2_ADDR_I,
	input wire logic HW_CONFIG_REG1_MEMSEL_I,
	input wire ppm_alt_s ALT_I,
	input wire ppm_evt_cfg_s EVT_CFG_I,
	input wire ppm_drv_s P1_DRV_O,
	input wire ppm_drv_s P2_DRV_O,
	input wire ppm_drv_s P3_DRV_O,
	input wire ppm_evt_s EVT_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	wire msel = HW_CONFIG_REG1_MEMSEL_I;
	wire p1w = SFR_WR_I && SFR_ADDR_I == 8'hae;

	rd_idle_a: assert property (!SFR_RD_I |=> SFR_RDATA_O == 8'h00)
		else $error("read data not idle");
	rd_gap_a: assert property (SFR_RD_I && (SFR_ADDR_I < 8'hae
		|| SFR_ADDR_I > 8'hb3) |=> SFR_RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	p2_ext_a: assert property (msel |=> P2_DRV_O.oe == 8'hff
		&& P2_DRV_O.out == $past(P2_ADDR_I))
		else $error("port 2 not on address");
	rd_strobe_a: assert property (msel |=> P3_DRV_O.oe[7]
		&& P3_DRV_O.out[7] == $past(ALT_I.rd_n))
		else $error("read strobe not driven");
	wr_strobe_a: assert property (msel |=> P3_DRV_O.oe[6]
		&& P3_DRV_O.out[6] == $past(ALT_I.wr_n))
		else $error("write strobe not driven");
	push_pull_a: assert property (p1w && SFR_WDATA_I[3:2] == 2'b01
		|=> P1_DRV_O.oe[1])
		else $error("push-pull pin not driven");
	input_only_a: assert property (p1w && SFR_WDATA_I[7:6] == 2'b11
		|=> !P1_DRV_O.oe[3])
		else $error("input pin driven");
	cnt_pulse_a: assert property (EVT_O.cnt0 |=> !EVT_O.cnt0)
		else $error("count pulse too long");
	cnt_gate_a: assert property (!EVT_CFG_I.cnt1_ext [*5] |-> !EVT_O.cnt1)
		else $error("count while disabled");
endmodule

bind ppm_port ppm_port_monitor mon (.CLK_I, .RST_N_I, .SFR_ADDR_I,
	.SFR_WDATA_I, .SFR_WR_I, .SFR_RD_I, .SFR_RDATA_O, .P2_ADDR_I,
	.HW_CONFIG_REG1_MEMSEL_I, .ALT_I, .EVT_CFG_I, .P1_DRV_O, .P2_DRV_O,
	.P3_DRV_O, .EVT_O);

// File: dv/ppm_pin_model.sv
`timescale 1ns/1ps
module ppm_pin_model
	import ppm_pkg::*;
(
	input wire ppm_drv_s drv_i,
	input wire logic [7:0] ext_i,
	input wire logic [7:0] ext_en_i,
	output logic [7:0] pin_o
);
	// device driver wins, then board driver, then weak pull-up
	// a floating pin without pull-up shows the inverse of the current drv_i.out bit
	assign pin_o = (drv_i.oe & drv_i.out) | (~drv_i.oe & ext_en_i & ext_i)
		| (~drv_i.oe & ~ext_en_i & (drv_i.pu | ~drv_i.out));
endmodule

// File: dv/ppm_port_tb.sv
`timescale 1ns/1ps
module ppm_port_tb
	import ppm_pkg::*;
;
	logic clk, rst_n, wr, rd, ea_n, msel;
	logic [7:0] addr, wdata, rdata, p1d, p2d, p2a, ext, p3pin;
	ppm_alt_s alt;
	ppm_evt_cfg_s cfg;
	ppm_drv_s d1, d2, d3;
	ppm_evt_s evt;
	int num_errors, compares;
	logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};

	ppm_port uut (.CLK_I(clk), .RST_N_I(rst_n), .SFR_ADDR_I(addr),
		.SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd),
		.SFR_RDATA_O(rdata), .P1_DATA_I(p1d), .P2_DATA_I(p2d),
		.P2_ADDR_I(p2a), .EXTERNAL_ACCESS_PIN_N_I(ea_n),
		.HW_CONFIG_REG1_MEMSEL_I(msel), .ALT_I(alt), .EVT_CFG_I(cfg),
		.P1_PIN_I(8'hff), .P2_PIN_I(8'hff), .P3_PIN_I(p3pin),
		.P1_DRV_O(d1), .P2_DRV_O(d2), .P3_DRV_O(d3), .EVT_O(evt));
	ppm_pin_model far (.drv_i(d3), .ext_i(ext), .ext_en_i(8'h3c),
		.pin_o(p3pin));

	initial
	begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, d);
		addr = a;
		wdata = d;
		wr = 1;
		tick;
		wr = 0;
		tick;
	endtask

	task automatic rd_chk(input logic [7:0] a, e);
		addr = a;
		rd = 1;
		tick;
		rd = 0;
		chk("rdata", e, rdata);
		tick;
	endtask

	// falling edge on pins 2-5, expect flags cnt0 cnt1 irq0 irq1
	task automatic ev_run(input logic [7:0] e);
		logic [3:0] s;
		s = 0;
		ext = 8'hff;
		repeat (6) tick;
		ext = 8'hc3;
		repeat (8)
		begin
			tick;
			s |= {evt.cnt0, evt.cnt1, evt.irq0, evt.irq1};
		end
		chk("events", e, {4'h0, s});
	endtask

	task automatic stop_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#40000;
		num_errors++;
		stop_test;
	end

	initial
	begin
		{wr, rd, msel, rst_n, addr, wdata} = '0;
		{p1d, p2d, p2a, cfg, num_errors, compares} = '0;
		ea_n = 1;
		ext = 8'hff;
		alt = 6'b110100; // strobes idle, transmit line high
		repeat (4) tick;
		rst_n = 1;
		for (int i = 0; i < 6; i++)
			rd_chk(8'(i + 'hae), rst_tab[i]);
		rd_chk(8'hb4, 8'h00);
		for (int i = 0; i < 6; i++)
			if (i != 2)
				wr_reg(8'(i + 'hae), 8'he4);
		tick;
		chk("p1 oe", 8'h77, d1.oe);
		chk("p2 oe", 8'h77, d2.oe);
		chk("p3 oe", 8'h02, d3.oe);
		chk("p1 pu", 8'h11, d1.pu);
		chk("p2 pu", 8'h11, d2.pu);
		chk("p3 pu", 8'hf1, d3.pu);
		p1d = 8'hff;
		p2d = 8'hff;
		tick;
		chk("p1 oe", 8'h22, d1.oe);
		chk("p2 oe", 8'h22, d2.oe);
		chk("p1 out", 8'h33, d1.out & 8'h77);
		chk("p2 out", 8'h33, d2.out & 8'h77);
		rd_chk(8'hb3, 8'he4);
		wr_reg(8'hb0, 8'h00);
		tick;
		chk("p3 oe", 8'hf7, d3.oe);
		chk("p3 out", 8'h00, d3.out & 8'hf7);
		wr_reg(8'hb0, 8'hff);
		alt.ser0_mode0 = 1;
		tick;
		chk("p3 out", 8'h00, d3.out & 8'h03);
		alt.ser0_mode0 = 0;
		tick;
		chk("p3 out", 8'h03, d3.out & 8'h03);
		wr_reg(8'hb0, 8'h00);
		msel = 1;
		p2a = 8'h5a;
		alt.rd_n = 0;
		tick;
		chk("p2 out", 8'h5a, d2.out);
		chk("p2 oe", 8'hff, d2.oe);
		chk("p3 oe", 8'hc0, d3.oe & 8'hc0);
		chk("p3 out", 8'h40, d3.out & 8'hc0);
		msel = 0;
		ea_n = 0;
		repeat (4) tick;
		chk("p2 out", 8'h5a, d2.out);
		ea_n = 1;
		alt.rd_n = 1;
		wr_reg(8'hb0, 8'hff);
		cfg = 6'h3f;
		ev_run(8'h0f);
		cfg = 6'h00;
		ev_run(8'h00);
		// both interrupts enabled in level mode
		cfg = 6'h0c;
		ev_run(8'h03);
		chk("rx", 8'h01, {7'h00, evt.ser0_rx});
		wr_reg(8'hb0, 8'hfe);
		repeat (2) tick;
		chk("rx", 8'h00, {7'h00, evt.ser0_rx});
		stop_test;
	end
endmodule
